// file: design/dtecl_defs.svh
// constants for the terminal control-lead block: offsets, fields, resets and timing
`ifndef DTECL_DEFS_SVH
`define DTECL_DEFS_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define DTECL_OFF_IFACE   12'h000
`define DTECL_OFF_MODES   12'h004
`define DTECL_OFF_CLOCK   12'h008
`define DTECL_OFF_COMMIT  12'h00C
`define DTECL_OFF_EVENT   12'h010
`define DTECL_OFF_STATUS  12'h014
// ---------------------------------------------------------------
// field positions in the modes word (two bits each)
// ---------------------------------------------------------------
`define DTECL_MODE_RLSD_LSB  0
`define DTECL_MODE_DSR_LSB   2
`define DTECL_MODE_CTS_LSB   4
`define DTECL_MODE_TM_LSB    6
`define DTECL_MODE_CA_LSB    8
`define DTECL_MODE_LOSS_LSB  10
`define DTECL_MODE_HLOSS_LSB 12
// interface word: personality in [1:0], toggle interval in [6:4]
`define DTECL_IFACE_PERS_LSB 0
`define DTECL_IFACE_TOG_LSB  4
// clock word: bit0 reference (1 = returned clock), bit1 tx invert, bit2 rx invert
`define DTECL_CLK_REF_BIT    0
`define DTECL_CLK_TXINV_BIT  1
`define DTECL_CLK_RXINV_BIT  2
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define DTECL_RST_IFACE  32'h0000_0000
// all leads automatic, loss from rts, hssi loss from ta
`define DTECL_RST_MODES  32'h0000_26AA
`define DTECL_RST_CLOCK  32'h0000_0001
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define DTECL_CLK_MHZ      200
`define DTECL_TICK_MS      1
`define DTECL_TICK_CYCLES  (`DTECL_CLK_MHZ * 1000 * `DTECL_TICK_MS)
`define DTECL_HALF_SEC_MS  500
`define DTECL_HALF_TICKS   (`DTECL_HALF_SEC_MS / `DTECL_TICK_MS)
`endif

// file: design/dtecl_pkg.sv
// types shared by the terminal control-lead block
`default_nettype none
package dtecl_pkg;
  // terminal personality, v35 first so it is the reset code
  typedef enum logic [1:0] {DTECL_V35, DTECL_RS449, DTECL_X21, DTECL_HSSI} dtecl_pers_t;
  // lead mode; automatic is code 2
  typedef enum logic [1:0] {DTECL_FORCE_OFF, DTECL_FORCE_ON, DTECL_AUTO, DTECL_MODE_RSV} dtecl_mode_t;
  // loss criterion
  typedef enum logic [1:0] {DTECL_LOSS_NONE, DTECL_LOSS_RTS, DTECL_LOSS_DTR, DTECL_LOSS_RSV} dtecl_loss_t;
endpackage : dtecl_pkg
`default_nettype wire

// file: design/dtecl_sync.sv
// three-stage input synchroniser with agreement of the last two stages
`timescale 1ns/1ps
`default_nettype none
module dtecl_sync
(
  input  wire logic sys_clk_i,  // system clock
  input  wire logic rst_b_i,    // synchronous reset, active low
  input  wire logic async_i,    // level from outside the domain
  output logic      level_o     // filtered level
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic s1;   // first stage, read only by s2
    logic s2;
    logic s3;
    logic lvl;
  } dtecl_sync_st_t;
  dtecl_sync_st_t st;
  dtecl_sync_st_t next_st;

  // next state: level moves only once stages two and three agree
  always_comb
  begin
    next_st     = st;
    next_st.s1  = async_i;
    next_st.s2  = st.s1;
    next_st.s3  = st.s2;
    if (st.s2 == st.s3)
    begin
      next_st.lvl = st.s3;
    end
  end

  // register the state
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign level_o = st.lvl;
endmodule : dtecl_sync
`default_nettype wire

// file: design/dtecl_tick.sv
// millisecond tick divider for the toggle timer
`timescale 1ns/1ps
`default_nettype none
`include "dtecl_defs.svh"
module dtecl_tick
#(
  parameter int TICK_CYCLES = `DTECL_TICK_CYCLES  // cycles per tick
)
(
  input  wire logic sys_clk_i,  // system clock
  input  wire logic rst_b_i,    // synchronous reset, active low
  output logic      tick_o      // one-cycle enable
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [19:0] cnt;   // cycles left in this tick
    logic        tick;
  } dtecl_tick_st_t;
  dtecl_tick_st_t st;
  dtecl_tick_st_t next_st;

  // count down and pulse on wrap
  always_comb
  begin
    next_st      = st;
    next_st.tick = 1'b0;
    if (st.cnt == 20'h0_0000)
    begin
      next_st.cnt  = 20'(TICK_CYCLES - 1);
      next_st.tick = 1'b1;
    end
    else
    begin
      next_st.cnt = st.cnt - 20'h0_0001;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign tick_o = st.tick;
endmodule : dtecl_tick
`default_nettype wire

// file: design/dtecl_top.sv
// terminal control leads, clock selection and loss detection behind an axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
`include "dtecl_defs.svh"
module dtecl_top
  import dtecl_pkg::*;
#(
  parameter int TICK_CYCLES = `DTECL_TICK_CYCLES  // cycles per millisecond tick
)
(
  input  wire logic        sys_clk_i,      // system clock, 200 mhz
  input  wire logic        rst_b_i,        // synchronous reset, active low
  // axi4-lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // system events
  input  wire logic        port_oos_i,     // pulse: a network port left service
  input  wire logic        net_loop_i,     // pulse: a network loopback was set
  input  wire logic        net_clean_i,    // link up with clean signal
  input  wire logic        net_any_i,      // at least one network signal active
  // terminal inputs (asynchronous)
  input  wire logic        dte_rts_i,      // rts, or x21 control
  input  wire logic        dte_dtr_i,
  input  wire logic        dte_test_i,     // test-enabling leads
  input  wire logic        dte_ta_i,       // hssi ta
  input  wire logic        dte_scte_i,     // returned clock, or x21 x
  input  wire logic        sct_i,          // own transmit clock
  input  wire logic        rxc_i,          // own receive clock
  // terminal outputs
  output logic             dte_rlsd_o,     // carrier detect, or x21 indication
  output logic             dte_ca_o,
  output logic             dte_dsr_o,
  output logic             dte_cts_o,
  output logic             dte_tm_o,
  output logic             dte_sct_o,      // transmit clock to terminal, or x21 s
  output logic             dte_rxc_o,      // receive clock to terminal
  output logic             tx_ref_o,       // transmit timing reference
  output logic             dte_loss_o      // terminal loss of signal
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] p_iface;   // pending settings
    logic [31:0] p_modes;
    logic [31:0] p_clock;
    logic [31:0] c_iface;   // committed settings
    logic [31:0] c_modes;
    logic [31:0] c_clock;
    logic [11:0] tog_cnt;   // ms left in toggle interval
    logic        aw_hold;
    logic [11:0] aw_addr;
    logic        w_hold;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rlsd;
    logic        ca;
    logic        dsr;
    logic        cts;
    logic        tm;
    logic        loss;
    logic        sct;
    logic        rxc;
    logic        txref;
  } dtecl_st_t;
  dtecl_st_t st;
  dtecl_st_t next_st;

  logic tick;       // millisecond enable
  logic rts_s;      // synchronised terminal leads
  logic dtr_s;
  logic test_s;
  logic ta_s;
  logic scte_s;
  logic sct_s;
  logic rxc_s;

  // ---------------------------------------------------------------
  // synchronisers and divider
  // ---------------------------------------------------------------
  logic [6:0] raw_in;
  logic [6:0] syn_out;
  assign raw_in = {dte_rts_i, dte_dtr_i, dte_test_i, dte_ta_i, dte_scte_i, sct_i, rxc_i};
  assign {rts_s, dtr_s, test_s, ta_s, scte_s, sct_s, rxc_s} = syn_out;

  // one synchroniser per outside lead
  for (genvar g = 0; g < 7; g++)
  begin : g_sync
    dtecl_sync u_sync
    (
      .sys_clk_i (sys_clk_i),
      .rst_b_i   (rst_b_i),
      .async_i   (raw_in[g]),
      .level_o   (syn_out[g])
    );
  end

  dtecl_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick
  (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .tick_o    (tick)
  );

  // ---------------------------------------------------------------
  // decoded committed settings
  // ---------------------------------------------------------------
  dtecl_pers_t pers;
  dtecl_mode_t m_rlsd;
  dtecl_mode_t m_dsr;
  dtecl_mode_t m_cts;
  dtecl_mode_t m_tm;
  dtecl_mode_t m_ca;
  dtecl_loss_t m_loss;
  logic [2:0]  tog_sel;
  logic        hloss_ta;    // hssi criterion: 1 = ta, 0 = none
  assign pers     = dtecl_pers_t'(st.c_iface[`DTECL_IFACE_PERS_LSB +: 2]);
  assign tog_sel  = st.c_iface[`DTECL_IFACE_TOG_LSB +: 3];
  assign m_rlsd   = dtecl_mode_t'(st.c_modes[`DTECL_MODE_RLSD_LSB +: 2]);
  assign m_dsr    = dtecl_mode_t'(st.c_modes[`DTECL_MODE_DSR_LSB +: 2]);
  assign m_cts    = dtecl_mode_t'(st.c_modes[`DTECL_MODE_CTS_LSB +: 2]);
  assign m_tm     = dtecl_mode_t'(st.c_modes[`DTECL_MODE_TM_LSB +: 2]);
  assign m_ca     = dtecl_mode_t'(st.c_modes[`DTECL_MODE_CA_LSB +: 2]);
  assign m_loss   = dtecl_loss_t'(st.c_modes[`DTECL_MODE_LOSS_LSB +: 2]);
  assign hloss_ta = st.c_modes[`DTECL_MODE_HLOSS_LSB + 1];

  // lead mode resolution; reserved code behaves as forced off
  function automatic logic lead(input dtecl_mode_t m, input logic auto_cond);
    logic r;
    r = 1'b0;
    unique case (m)
      DTECL_FORCE_ON: r = 1'b1;
      DTECL_AUTO:     r = auto_cond;
      default:        r = 1'b0;
    endcase
    return r;
  endfunction : lead

  // toggle interval in ticks: 0 or 5 to 7 means none, else n half seconds
  logic [11:0] tog_len;
  always_comb
  begin
    tog_len = 12'h000;
    if (tog_sel <= 3'h4)
    begin
      tog_len = 12'(tog_sel * `DTECL_HALF_TICKS);
    end
  end

  logic rate_evt;
  assign rate_evt = port_oos_i | net_loop_i;

  // ---------------------------------------------------------------
  // bus, settings and leads
  // ---------------------------------------------------------------
  logic        wr_go;
  logic        rd_go;
  logic [31:0] wmask;
  assign wr_go = st.aw_hold && st.w_hold && !st.bvalid;
  assign rd_go = s_axi_arvalid && !st.rvalid;
  assign wmask = {{8{st.w_strb[3]}}, {8{st.w_strb[2]}}, {8{st.w_strb[1]}}, {8{st.w_strb[0]}}};

  always_comb
  begin
    next_st = st;
    // accept address and data separately, in either order
    if (s_axi_awvalid && !st.aw_hold)
    begin
      next_st.aw_hold = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_hold)
    begin
      next_st.w_hold = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    // perform write once both halves are here
    if (wr_go)
    begin
      next_st.aw_hold = 1'b0;
      next_st.w_hold  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = 2'b00;
      unique case (st.aw_addr)
        `DTECL_OFF_IFACE:
          next_st.p_iface = (st.p_iface & ~wmask) | (st.w_data & wmask & 32'h0000_0073);
        `DTECL_OFF_MODES:
          next_st.p_modes = (st.p_modes & ~wmask) | (st.w_data & wmask & 32'h0000_3FFF);
        `DTECL_OFF_CLOCK:
          next_st.p_clock = (st.p_clock & ~wmask) | (st.w_data & wmask & 32'h0000_0007);
        `DTECL_OFF_COMMIT:
          begin
            // all pending settings take effect at once
            if (st.w_strb[0] && st.w_data[0])
            begin
              next_st.c_iface = st.p_iface;
              next_st.c_modes = st.p_modes;
              next_st.c_clock = st.p_clock;
            end
          end
        `DTECL_OFF_EVENT: ;    // software rate event, handled below
        default: next_st.bresp = 2'b10;
      endcase
    end
    if (st.bvalid && s_axi_bready)
    begin
      next_st.bvalid = 1'b0;
    end
    // reads answer one cycle after address
    if (rd_go)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = 2'b00;
      unique case (s_axi_araddr)
        `DTECL_OFF_IFACE:  next_st.rdata = st.p_iface;
        `DTECL_OFF_MODES:  next_st.rdata = st.p_modes;
        `DTECL_OFF_CLOCK:  next_st.rdata = st.p_clock;
        `DTECL_OFF_COMMIT: next_st.rdata = 32'h0000_0000;
        `DTECL_OFF_EVENT:  next_st.rdata = 32'h0000_0000;
        `DTECL_OFF_STATUS:
          next_st.rdata = {19'h0_0000, st.tog_cnt != 12'h000, st.loss,
                           st.rlsd, st.ca, st.dsr, st.cts, st.tm, 6'h00};
        default:
          begin
            next_st.rdata = 32'h0000_0000;
            next_st.rresp = 2'b10;
          end
      endcase
    end
    else if (st.rvalid && s_axi_rready)
    begin
      next_st.rvalid = 1'b0;
    end
    // toggle timer: a new event restarts the interval
    if (rate_evt || (wr_go && st.aw_addr == `DTECL_OFF_EVENT && st.w_data[0]))
    begin
      next_st.tog_cnt = tog_len;
    end
    else if (tick && st.tog_cnt != 12'h000)
    begin
      next_st.tog_cnt = st.tog_cnt - 12'h001;
    end
    // presence lead: rlsd, or ca in hssi, is held low while timer runs
    next_st.rlsd = (pers != DTECL_HSSI) && (st.tog_cnt == 12'h000)
                   && lead(m_rlsd, net_clean_i);
    next_st.ca   = (pers == DTECL_HSSI) && (st.tog_cnt == 12'h000)
                   && lead(m_ca, net_any_i);
    // rts input doubles as x21 control
    next_st.dsr  = (pers != DTECL_HSSI) && lead(m_dsr, dtr_s);
    next_st.cts  = (pers != DTECL_HSSI) && lead(m_cts, rts_s);
    next_st.tm   = (pers != DTECL_HSSI) && lead(m_tm, test_s);
    // loss of signal from the chosen lead
    if (pers == DTECL_HSSI)
    begin
      next_st.loss = hloss_ta && !ta_s;
    end
    else
    begin
      unique case (m_loss)
        DTECL_LOSS_RTS: next_st.loss = !rts_s;
        DTECL_LOSS_DTR: next_st.loss = !dtr_s;
        default:        next_st.loss = 1'b0;
      endcase
    end
    // clocks: x21 s and x share the sct and scte paths
    next_st.txref = st.c_clock[`DTECL_CLK_REF_BIT] ? scte_s : sct_s;
    next_st.sct   = sct_s ^ st.c_clock[`DTECL_CLK_TXINV_BIT];
    next_st.rxc   = rxc_s ^ st.c_clock[`DTECL_CLK_RXINV_BIT];
  end

  // register all state; reset sets documented defaults
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      st         <= '0;
      st.p_iface <= `DTECL_RST_IFACE;
      st.p_modes <= `DTECL_RST_MODES;
      st.p_clock <= `DTECL_RST_CLOCK;
      st.c_iface <= `DTECL_RST_IFACE;
      st.c_modes <= `DTECL_RST_MODES;
      st.c_clock <= `DTECL_RST_CLOCK;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = !st.aw_hold;
  assign s_axi_wready  = !st.w_hold;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;
  assign dte_rlsd_o    = st.rlsd;
  assign dte_ca_o      = st.ca;
  assign dte_dsr_o     = st.dsr;
  assign dte_cts_o     = st.cts;
  assign dte_tm_o      = st.tm;
  assign dte_sct_o     = st.sct;
  assign dte_rxc_o     = st.rxc;
  assign tx_ref_o      = st.txref;
  assign dte_loss_o    = st.loss;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  chk_toggle_low: assert property (st.tog_cnt != 12'h000 |=> !st.rlsd && !st.ca)
    else $error("presence lead high during toggle");
  chk_toggle_start: assert property (rate_evt && tog_len != 12'h000 |=> st.tog_cnt == $past(tog_len))
    else $error("toggle interval not started");
  chk_none_interval: assert property (rate_evt && tog_sel == 3'h0 |=> st.tog_cnt == 12'h000)
    else $error("none interval started timer");
  chk_cts_auto: assert property (m_cts == DTECL_AUTO && pers != DTECL_HSSI && $stable(m_cts)
                                 |=> st.cts == $past(rts_s))
    else $error("cts does not follow rts");
  chk_dsr_force: assert property ((m_dsr == DTECL_FORCE_ON && pers != DTECL_HSSI) [*2] |-> st.dsr)
    else $error("forced dsr low");
  chk_loss_none: assert property ((m_loss == DTECL_LOSS_NONE && pers != DTECL_HSSI) [*2] |-> !st.loss)
    else $error("loss flag with detection none");
  chk_commit_hold: assert property (!(wr_go && st.aw_addr == `DTECL_OFF_COMMIT) |=> $stable(st.c_modes))
    else $error("settings moved without commit");
  chk_txref_sel: assert property (st.c_clock[`DTECL_CLK_REF_BIT] && $stable(st.c_clock)
                                  |=> st.txref == $past(scte_s))
    else $error("tx reference not returned clock");
  chk_hssi_loss: assert property (pers == DTECL_HSSI && hloss_ta && $stable(st.c_modes)
                                  |=> st.loss == !$past(ta_s))
    else $error("hssi loss wrong");

  cov_toggle: cover property (rate_evt ##1 st.tog_cnt != 12'h000);
  cov_commit: cover property (wr_go && st.aw_addr == `DTECL_OFF_COMMIT);
  cov_hssi:   cover property (pers == DTECL_HSSI && st.ca);
  cov_loss:   cover property (st.loss);
endmodule : dtecl_top
`default_nettype wire

// file: sim/dtecl_dte_model.sv
// behavioural terminal: control leads and the looped-back transmit clock
`timescale 1ns/1ps
`default_nettype none
module dtecl_dte_model
(
  input  wire logic sys_clk_i,  // bench clock, lead changes follow its edges
  input  wire logic sct_i,      // transmit clock offered to the terminal
  output logic      scte_o,     // clock returned by the terminal
  output logic      rts_o,      // request to send, or x21 control
  output logic      dtr_o,      // terminal ready
  output logic      test_o,     // test-enabling leads
  output logic      ta_o        // hssi terminal available
);
  initial scte_o = 1'b0;
  initial {rts_o, dtr_o, test_o, ta_o} = 4'h0;
  // the loop through the cable lags, so the returned edge is late
  always @(sct_i) scte_o <= #3 sct_i;
  // leads move just after an edge, as the terminal's own logic would
  task automatic set_leads(input logic [3:0] v);
    @(posedge sys_clk_i);
    {rts_o, dtr_o, test_o, ta_o} <= v;
  endtask : set_leads
endmodule : dtecl_dte_model
`default_nettype wire

// file: sim/tb_dtecl_top.sv
// bench for the terminal control-lead block: bus tasks, lead scenarios, verdict
`timescale 1ns/1ps
`default_nettype none
`include "dtecl_defs.svh"
module tb_dtecl_top;
  import dtecl_pkg::*;
  // ----------
  // signals
  // ----------
  localparam int TICKS = 4;                          // short tick keeps runs brief
  localparam int HALF  = `DTECL_HALF_TICKS * TICKS;  // cycles in half a second
  localparam int LIMIT = 40000;                      // hang ceiling in cycles
  logic        sys_clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        lnk_clk = 1'b0;  // link clock, still while lnk_run is low
  logic        lnk_run = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        port_oos_i = 1'b0, net_loop_i = 1'b0, net_clean_i = 1'b1, net_any_i = 1'b0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         dte_rts_i, dte_dtr_i, dte_test_i, dte_ta_i, dte_scte_i;
  wire         dte_rlsd_o, dte_ca_o, dte_dsr_o, dte_cts_o, dte_tm_o;
  wire         dte_sct_o, dte_rxc_o, tx_ref_o, dte_loss_o;
  wire  [5:0]  leads = {dte_rlsd_o, dte_ca_o, dte_dsr_o, dte_cts_o, dte_tm_o, dte_loss_o};
  logic [2:0]  ck_w [3] = '{3'h1, 3'h3, 3'h6};  // clock words tried
  logic [2:0]  ck_e [3] = '{3'h7, 3'h1, 3'h4};  // {reference, tx out, rx out}
  int          error_cnt = 0, check_count = 0, cyc = 0;

  dtecl_top #(.TICK_CYCLES(TICKS)) dut
  (
    .sys_clk_i, .rst_b_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .port_oos_i, .net_loop_i, .net_clean_i, .net_any_i,
    .dte_rts_i, .dte_dtr_i, .dte_test_i, .dte_ta_i, .dte_scte_i, .sct_i(lnk_clk),
    .rxc_i(lnk_clk), .dte_rlsd_o, .dte_ca_o, .dte_dsr_o, .dte_cts_o, .dte_tm_o,
    .dte_sct_o, .dte_rxc_o, .tx_ref_o, .dte_loss_o
  );
  dtecl_dte_model dte
  (
    .sys_clk_i, .sct_i(dte_sct_o), .scte_o(dte_scte_i), .rts_o(dte_rts_i),
    .dtr_o(dte_dtr_i), .test_o(dte_test_i), .ta_o(dte_ta_i)
  );

  always #2.5 sys_clk_i = ~sys_clk_i;
  // link clock has its own phase and stops between bursts
  always #32 if (lnk_run) lnk_clk = ~lnk_clk;
  // ----------
  // tasks
  // ----------
  task automatic end_sim;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] rsp);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge sys_clk_i);
      aw_ok = aw_ok | s_axi_awready;
      w_ok = w_ok | s_axi_wready;
      s_axi_awvalid <= !aw_ok;
      s_axi_wvalid <= !w_ok;
    end
    // raised here so a back-to-back call never re-drives it in the release step
    s_axi_bready <= 1'b1;
    do @(posedge sys_clk_i); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check(32'(s_axi_bresp), 32'(rsp));
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] rsp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge sys_clk_i); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk_i); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, exp);
    check(32'(s_axi_rresp), 32'(rsp));
  endtask : axi_rd
  // settings only bite after the commit strobe
  task automatic apply(input logic [11:0] a, input logic [31:0] d);
    axi_wr(a, d, 2'h0);
    axi_wr(`DTECL_OFF_COMMIT, 32'h0000_0001, 2'h0);
  endtask : apply
  task automatic gap(input int n, input logic [5:0] e);
    repeat (n) @(posedge sys_clk_i);
    check(32'(leads), 32'(e));
  endtask : gap
  task automatic pulse(input logic oos);
    port_oos_i <= oos;
    net_loop_i <= !oos;
    @(posedge sys_clk_i);
    port_oos_i <= 1'b0;
    net_loop_i <= 1'b0;
  endtask : pulse
  // hang guard: a stuck wait ends the run as a failure
  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      error_cnt++;
      end_sim();
    end
  end
  // ----------
  // scenarios
  // ----------
  initial
  begin
    repeat (6) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    @(posedge sys_clk_i);
    axi_rd(`DTECL_OFF_IFACE, 32'h0000_0000, 2'h0);   // v35, no toggle
    axi_rd(`DTECL_OFF_MODES, `DTECL_RST_MODES, 2'h0); // auto leads
    axi_rd(`DTECL_OFF_CLOCK, 32'h0000_0001, 2'h0);   // returned clock, normal
    axi_rd(12'h020, 32'h0000_0000, 2'h2);            // unmapped read refused
    axi_wr(`DTECL_OFF_STATUS, 32'h0000_0001, 2'h2);  // status is read-only
    gap(12, 6'h21);                                   // rts absent
    net_clean_i <= 1'b0;
    gap(12, 6'h01);                                   // unclean network drops rlsd
    net_clean_i <= 1'b1;
    dte.set_leads(4'ha);
    gap(12, 6'h26);                                   // rts and test up
    dte.set_leads(4'h4);
    gap(12, 6'h29);                                   // dtr drives dsr
    axi_wr(`DTECL_OFF_MODES, 32'h0000_2AAA, 2'h0);
    gap(12, 6'h29);                                   // held until commit
    s_axi_wstrb <= 4'he;
    axi_wr(`DTECL_OFF_COMMIT, 32'h0000_0001, 2'h0);
    s_axi_wstrb <= 4'hf;
    gap(12, 6'h29);                                   // commit with lane 0 off ignored
    axi_wr(`DTECL_OFF_COMMIT, 32'h0000_0001, 2'h0);
    gap(12, 6'h28);                                   // dtr criterion
    apply(`DTECL_OFF_MODES, 32'h0000_22AA);
    dte.set_leads(4'h0);
    gap(12, 6'h20);                                   // no detection
    for (int m = 0; m < 2; m++)
    begin
      apply(`DTECL_OFF_MODES, 32'h0000_2000 | (32'(m) * 32'h0000_0155));
      gap(12, {m[0], 1'b0, m[0], m[0], m[0], 1'b0});  // forced
    end
    lnk_run = 1'b1;
    repeat (100) @(posedge sys_clk_i);
    wait (lnk_clk);
    lnk_run = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      apply(`DTECL_OFF_CLOCK, {29'h0, ck_w[i]});
      repeat (12) @(posedge sys_clk_i);
      check(32'({tx_ref_o, dte_sct_o, dte_rxc_o}), 32'(ck_e[i]));  // clock select
    end
    apply(`DTECL_OFF_MODES, 32'h0000_06AA);
    apply(`DTECL_OFF_IFACE, 32'h0000_0001);
    gap(12, 6'h21);                                   // rs-449 personality
    apply(`DTECL_OFF_IFACE, 32'h0000_0002);
    dte.set_leads(4'h8);
    gap(12, 6'h24);                                   // x21 control
    dte.set_leads(4'h0);
    pulse(1'b1);
    gap(12, 6'h21);                                   // no interval, no drop
    apply(`DTECL_OFF_IFACE, 32'h0000_0010);
    pulse(1'b1);
    gap(12, 6'h01);                                   // port out of service
    axi_rd(`DTECL_OFF_STATUS, 32'h0000_1800, 2'h0);  // timer and loss flags
    gap(HALF - 112, 6'h01);                           // still held low
    gap(200, 6'h21);                                  // restored after half s
    pulse(1'b0);
    gap(12, 6'h01);                                   // loopback set
    gap(HALF + 100, 6'h21);                           // restored
    apply(`DTECL_OFF_MODES, 32'h0000_26AA);
    apply(`DTECL_OFF_IFACE, 32'h0000_0043);
    net_any_i <= 1'b1;
    dte.set_leads(4'h1);
    gap(12, 6'h10);                                   // hssi ca leads
    axi_wr(`DTECL_OFF_EVENT, 32'h0000_0001, 2'h0);
    gap(12, 6'h00);                                   // ca dropped
    gap(4 * HALF - 112, 6'h00);                       // two seconds held
    gap(200, 6'h10);                                  // ca back
    dte.set_leads(4'h0);
    gap(12, 6'h11);                                   // ta absent
    net_any_i <= 1'b0;
    gap(12, 6'h01);                                   // no network signal
    apply(`DTECL_OFF_MODES, 32'h0000_06AA);
    gap(12, 6'h00);                                   // hssi detection off
    end_sim();
  end
endmodule : tb_dtecl_top
`default_nettype wire
